// ### mpu_defs.svh
// constants for the memory protection unit: offsets, field positions, reset values, trap codes
`ifndef MPU_DEFS_SVH
`define MPU_DEFS_SVH

// ==========================================================
// register byte offsets (axi4-lite, one word each)
`define MPU_OFS_PSW 12'h000
`define MPU_OFS_ISB 12'h004
`define MPU_OFS_STAT 12'h008
`define MPU_OFS_CTRL 12'h00c
// range table window: base + set*0x100 + table*0x80 + entry*0x10 + word*4
`define MPU_OFS_TBL 12'h400

// ==========================================================
// status word field positions
`define MPU_PSW_PRS_HI 13
`define MPU_PSW_PRS_LO 12
`define MPU_PSW_IO_HI 11
`define MPU_PSW_IO_LO 10
`define MPU_PSW_IS 9
`define MPU_PSW_GW 8
`define MPU_PSW_CDE 7
`define MPU_PSW_CDC_HI 6
// protection fields writable: bits 13..0
`define MPU_PSW_MASK 32'h00003fff
// cde set, cdc zero, supervisor, interrupt stack, set 0
`define MPU_PSW_RST 32'h00000a80

// ==========================================================
// mode entry bits
`define MPU_M_WE 7
`define MPU_M_RE 6
`define MPU_M_WS 5
`define MPU_M_RS 4
`define MPU_M_WBL 3
`define MPU_M_RBL 2
`define MPU_M_WBU 1
`define MPU_M_RBU 0
`define MPU_M_XE 7

// ==========================================================
// trap classes and ids
`define MPU_TCLS_PROT 3'h1
`define MPU_TCLS_CTX 3'h3
`define MPU_TIN_MPR 8'h02
`define MPU_TIN_MPW 8'h03
`define MPU_TIN_MPX 8'h04
`define MPU_TIN_GLOBAL_WRITE_VIOLATION_TRAP 8'h07
`define MPU_TIN_CDO 8'h02

`endif

// ### mpu_pkg.sv
// types shared by the memory protection unit
package mpu_pkg;
  typedef enum logic [1:0] {
    mpu_io_user0,
    mpu_io_user1,
    mpu_io_super,
    mpu_io_resv
  } mpu_io_t;
  typedef enum logic [1:0] {
    mpu_acc_read,
    mpu_acc_write,
    mpu_acc_exec
  } mpu_acc_t;
endpackage : mpu_pkg

// ### mpu_range_check.sv
// one range table: in-range and bound-equality compare for every entry
`timescale 1ns/1ps
`include "mpu_defs.svh"
module mpu_range_check
  import mpu_pkg::*;
#(
  parameter int ENTRIES = 4
) (
  // address and table contents
  input wire logic [31:0] addr,
  input wire logic [ENTRIES*64-1:0] bounds,
  // per-entry results
  output logic [ENTRIES-1:0] in_range,
  output logic [ENTRIES-1:0] eq_lower,
  output logic [ENTRIES-1:0] eq_upper
);
  // ==========================================================
  // comparators
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_ent
      // lower inclusive, upper exclusive
      assign in_range[g] = (addr >= bounds[g*64 +: 32]) && (addr < bounds[g*64+32 +: 32]); // RQ14
      assign eq_lower[g] = addr == bounds[g*64 +: 32]; // RQ18
      assign eq_upper[g] = addr == bounds[g*64+32 +: 32]; // RQ18
    end
  endgenerate
endmodule : mpu_range_check

// ### mpu_call_depth.sv
// call depth counter decode: next value and overflow for one call
`timescale 1ns/1ps
`include "mpu_defs.svh"
module mpu_call_depth
  import mpu_pkg::*;
(
  // current field and enable
  input wire logic [6:0] cdc,
  input wire logic cde,
  // results of a call
  output logic [6:0] next_cdc,
  output logic overflow
);
  logic [6:0] cmask;
  logic [6:0] inc;
  // ==========================================================
  // counter bits are those below the first zero
  always_comb begin
    cmask = 7'h7f;
    for (int i = 6; i >= 0; i--) begin
      if (cdc[i] == 1'b0) begin
        cmask = 7'((8'h01 << i) - 8'h01);
        break;
      end
    end
  end
  assign inc = 7'((cdc & cmask) + 7'h01);
  // counting off when all ones or cde clear
  always_comb begin
    if (!cde || cdc == 7'h7f) begin // RQ8 RQ13
      next_cdc = cdc;
      overflow = 1'b0;
    end else if (cdc == 7'h7e) begin // RQ12
      next_cdc = cdc;
      overflow = 1'b1;
    end else begin
      // carry out of the counter field means overflow
      overflow = (inc & cmask) == 7'h00; // RQ10 RQ11
      next_cdc = (cdc & ~cmask) | (inc & cmask);
    end
  end
endmodule : mpu_call_depth

// ### mpu_top.sv
// memory protection unit: status word protection fields, range tables, checks
// Contract
// RQ1 - two-bit field selects active protection set
// RQ2 - privilege: user0, user1, supervisor, reserved
// RQ3 - user0 no interrupt toggle; user1 may disable
// RQ4 - only supervisor reaches core and protected registers
// RQ5 - stack bit one means interrupt stack
// RQ6 - interrupt from user stack loads base pointer
// RQ7 - global register writes need write permit
// RQ8 - counting needs enable and mask not all ones
// RQ9 - call instruction sets enable again
// RQ10 - field splits into ones mask and counter
// RQ11 - counter overflow raises a trap
// RQ12 - value 1111110 traps every call
// RQ13 - value 1111111 disables call depth counting
// RQ14 - range includes lower, excludes upper bound
// RQ15 - bounds word: upper high, lower low
// RQ16 - entry off when its enables clear
// RQ17 - no debug bits, no debug signal
// RQ18 - debug as range or bound equality
// RQ19 - data against data table, fetch against code
// RQ20 - hit entry gives permission and debug
// RQ21 - two to four identical sets
// RQ22 - supervisor still range checked
// RQ23 - global write denied raises trap seven
// RQ24 - denied read 2, write 3, fetch 4
// RQ25 - trap clears counter, limit sixty-four
// RQ26 - permitted only if a hit enables it; code permits every access while ctrl bit 0 (prot_en) is clear
`timescale 1ns/1ps
`include "mpu_defs.svh"
module mpu_top
  import mpu_pkg::*;
#(
  parameter int NSETS = 4,
  parameter int ENTRIES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // load/store unit
  input wire logic ls_valid,
  input wire logic ls_write,
  input wire logic [31:0] ls_addr,
  // fetch unit
  input wire logic if_valid,
  input wire logic [31:0] if_pc,
  // core events
  input wire logic core_call,
  input wire logic core_intr_take,
  input wire logic core_trap_take,
  input wire logic core_greg_write,
  input wire logic core_int_enable_req,
  input wire logic core_int_disable_req,
  input wire logic core_sfr_access,
  // results to core
  output logic ls_permit,
  output logic if_permit,
  output logic dbg_data,
  output logic dbg_code,
  output logic trap_valid,
  output logic [2:0] trap_class,
  output logic [7:0] trap_tin,
  output logic sp_load_isb,
  output logic [31:0] sp_value,
  output logic int_toggle_ok,
  output logic sfr_ok,
  output logic greg_write_ok
);
  localparam int TW = ENTRIES * 64;
  // ==========================================================
  // storage
  logic [31:0] program_status_word;
  logic [31:0] isb;
  logic prot_en;
  logic [TW-1:0] dbounds [NSETS];
  logic [TW-1:0] cbounds [NSETS];
  logic [ENTRIES*8-1:0] dmode [NSETS];
  logic [ENTRIES*8-1:0] cmode [NSETS];
  logic [1:0] protection_set_select;
  mpu_io_t io;
  logic [6:0] cdc_next;
  logic cd_ovf;
  logic [ENTRIES-1:0] d_in, d_eql, d_equ, c_in, c_eql, c_equ;
  logic d_ok, d_dbg, c_ok, c_dbg;
  logic [31:0] rd_word;
  logic rd_hit;
  initial assert (NSETS >= 2 && NSETS <= 4) else $error("set count out of range"); // RQ21

  assign protection_set_select = program_status_word[`MPU_PSW_PRS_HI:`MPU_PSW_PRS_LO]; // RQ1
  assign io = mpu_io_t'(program_status_word[`MPU_PSW_IO_HI:`MPU_PSW_IO_LO]); // RQ2

  // table address decode, used by read and write
  function automatic logic tbl_dec(input logic [11:0] a, output logic [1:0] s, output logic t,
                                   output logic [2:0] e, output logic [1:0] w);
    s = a[9:8];
    t = a[7];
    e = a[6:4];
    w = a[3:2];
    return a[11:10] == 2'h1 && int'(s) < NSETS && int'(e) < ENTRIES;
  endfunction : tbl_dec

  // ==========================================================
  // range checks on the active set
  mpu_range_check #(.ENTRIES(ENTRIES)) u_dchk (
    .addr(ls_addr),
    .bounds(dbounds[protection_set_select]), // RQ19
    .in_range(d_in),
    .eq_lower(d_eql),
    .eq_upper(d_equ)
  );
  mpu_range_check #(.ENTRIES(ENTRIES)) u_cchk (
    .addr(if_pc),
    .bounds(cbounds[protection_set_select]), // RQ19
    .in_range(c_in),
    .eq_lower(c_eql),
    .eq_upper(c_equ)
  );
  mpu_call_depth u_cd (
    .cdc(program_status_word[`MPU_PSW_CDC_HI:0]),
    .cde(program_status_word[`MPU_PSW_CDE]),
    .next_cdc(cdc_next),
    .overflow(cd_ovf)
  );

  // permission and debug from hit entries; privilege never bypasses this
  always_comb begin
    logic [7:0] m;
    m = 8'h00;
    d_ok = !prot_en;
    c_ok = !prot_en;
    d_dbg = 1'b0;
    c_dbg = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      m = dmode[protection_set_select][i*8 +: 8];
      if (d_in[i] && (ls_write ? m[`MPU_M_WE] : m[`MPU_M_RE])) d_ok = 1'b1; // RQ16 RQ20 RQ22 RQ26
      // cleared debug bits give nothing
      if (ls_write) d_dbg |= (m[`MPU_M_WS] & d_in[i]) | (m[`MPU_M_WBL] & d_eql[i]) | (m[`MPU_M_WBU] & d_equ[i]); // RQ17 RQ18
      else d_dbg |= (m[`MPU_M_RS] & d_in[i]) | (m[`MPU_M_RBL] & d_eql[i]) | (m[`MPU_M_RBU] & d_equ[i]); // RQ17 RQ18
      m = cmode[protection_set_select][i*8 +: 8];
      if (c_in[i] && m[`MPU_M_XE]) c_ok = 1'b1; // RQ16 RQ20 RQ26
      c_dbg |= (m[`MPU_M_RS] & c_in[i]) | (m[`MPU_M_RBL] & c_eql[i]) | (m[`MPU_M_RBU] & c_equ[i]); // RQ18
    end
  end

  // ==========================================================
  // status word: bus writes, call, interrupt and trap effects
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      program_status_word <= `MPU_PSW_RST;
    end else if (core_trap_take) begin
      // default trap state: set 0, all permits, interrupt stack, limit 64
      program_status_word[13:0] <= {2'h0, 2'h2, 1'b1, 1'b1, 1'b1, 7'h00}; // RQ25
    end else if (core_intr_take) begin
      program_status_word[`MPU_PSW_IS] <= 1'b1; // RQ5
    end else if (core_call) begin
      program_status_word[`MPU_PSW_CDC_HI:0] <= cdc_next; // RQ10
      program_status_word[`MPU_PSW_CDE] <= 1'b1; // RQ9
    end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr == `MPU_OFS_PSW) begin
      for (int b = 0; b < 2; b++) begin
        if (s_axi_wstrb[b]) program_status_word[b*8 +: 8] <= s_axi_wdata[b*8 +: 8] & 8'(`MPU_PSW_MASK >> (b*8));
      end
    end
  end

  // other software registers and range tables
  always_ff @(posedge ref_clk) begin
    logic [1:0] s;
    logic t;
    logic [2:0] e;
    logic [1:0] w;
    if (rst) begin
      isb <= 32'h00000000;
      prot_en <= 1'b0;
      for (int k = 0; k < NSETS; k++) begin
        dbounds[k] <= '0;
        cbounds[k] <= '0;
        dmode[k] <= '0;
        cmode[k] <= '0;
      end
    end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
      if (s_axi_awaddr == `MPU_OFS_ISB) isb <= s_axi_wdata;
      if (s_axi_awaddr == `MPU_OFS_CTRL) prot_en <= s_axi_wdata[0];
      if (tbl_dec(s_axi_awaddr, s, t, e, w)) begin
        // word 0 lower, 1 upper, 2 mode
        if (w == 2'h0 && !t) dbounds[s][e*64 +: 32] <= s_axi_wdata; // RQ15
        if (w == 2'h1 && !t) dbounds[s][e*64+32 +: 32] <= s_axi_wdata; // RQ15
        if (w == 2'h0 && t) cbounds[s][e*64 +: 32] <= s_axi_wdata;
        if (w == 2'h1 && t) cbounds[s][e*64+32 +: 32] <= s_axi_wdata;
        if (w == 2'h2 && !t) dmode[s][e*8 +: 8] <= s_axi_wdata[7:0];
        if (w == 2'h2 && t) cmode[s][e*8 +: 8] <= s_axi_wdata[7:0];
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel: takes address and data together, one cycle response
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_bvalid) begin
        if (s_axi_bready) s_axi_bvalid <= 1'b0;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        // unmapped address answers slverr
        s_axi_bresp <= (s_axi_awaddr[11:10] == 2'h0 && s_axi_awaddr <= `MPU_OFS_CTRL && s_axi_awaddr[1:0] == 2'h0)
                       || (s_axi_awaddr[11:10] == 2'h1 && int'(s_axi_awaddr[9:8]) < NSETS
                       && int'(s_axi_awaddr[6:4]) < ENTRIES) ? 2'h0 : 2'h2;
      end
    end
  end

  // read decode
  always_comb begin
    logic [1:0] s;
    logic t;
    logic [2:0] e;
    logic [1:0] w;
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    s = 2'h0;
    t = 1'b0;
    e = 3'h0;
    w = 2'h0;
    if (s_axi_araddr == `MPU_OFS_PSW) rd_word = program_status_word & `MPU_PSW_MASK;
    else if (s_axi_araddr == `MPU_OFS_ISB) rd_word = isb;
    else if (s_axi_araddr == `MPU_OFS_STAT) rd_word = {28'h0000000, trap_valid, ls_permit, if_permit, dbg_data};
    else if (s_axi_araddr == `MPU_OFS_CTRL) rd_word = {31'h00000000, prot_en};
    else if (tbl_dec(s_axi_araddr, s, t, e, w)) begin
      case (w)
        2'h0: rd_word = t ? cbounds[s][e*64 +: 32] : dbounds[s][e*64 +: 32];
        2'h1: rd_word = t ? cbounds[s][e*64+32 +: 32] : dbounds[s][e*64+32 +: 32];
        2'h2: rd_word = {24'h000000, t ? cmode[s][e*8 +: 8] : dmode[s][e*8 +: 8]};
        default: rd_word = 32'h00000000;
      endcase
    end else rd_hit = 1'b0;
  end

  // read channel, answer raised together with arready, one cycle after arvalid seen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end
    end
  end

  // ==========================================================
  // registered results and traps to the core, priority fetch, load/store, global write, call
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ls_permit <= 1'b1;
      if_permit <= 1'b1;
      dbg_data <= 1'b0;
      dbg_code <= 1'b0;
      trap_valid <= 1'b0;
      trap_class <= 3'h0;
      trap_tin <= 8'h00;
    end else begin
      ls_permit <= d_ok;
      if_permit <= c_ok;
      dbg_data <= ls_valid & d_dbg;
      dbg_code <= if_valid & c_dbg;
      trap_valid <= 1'b1;
      trap_class <= `MPU_TCLS_PROT;
      if (if_valid && !c_ok) trap_tin <= `MPU_TIN_MPX; // RQ24
      else if (ls_valid && !d_ok) trap_tin <= ls_write ? `MPU_TIN_MPW : `MPU_TIN_MPR; // RQ24
      else if (core_greg_write && !program_status_word[`MPU_PSW_GW]) trap_tin <= `MPU_TIN_GLOBAL_WRITE_VIOLATION_TRAP; // RQ23
      else if (core_call && cd_ovf) begin
        trap_class <= `MPU_TCLS_CTX; // RQ11
        trap_tin <= `MPU_TIN_CDO;
      end else begin
        trap_valid <= 1'b0;
        trap_class <= 3'h0;
        trap_tin <= 8'h00;
      end
    end
  end

  // privilege and stack answers to the core
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_toggle_ok <= 1'b0;
      sfr_ok <= 1'b0;
      greg_write_ok <= 1'b0;
      sp_load_isb <= 1'b0;
      sp_value <= 32'h00000000;
    end else begin
      // user0 neither, user1 disable only
      int_toggle_ok <= (io == mpu_io_super) || (io == mpu_io_user1 && core_int_disable_req && !core_int_enable_req); // RQ3
      sfr_ok <= core_sfr_access && io == mpu_io_super; // RQ4
      greg_write_ok <= core_greg_write && program_status_word[`MPU_PSW_GW]; // RQ7
      sp_load_isb <= core_intr_take && !program_status_word[`MPU_PSW_IS]; // RQ6
      sp_value <= isb;
    end
  end

  // ==========================================================
  // checks
  ls_trap_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ24
    ls_valid && !d_ok && !(if_valid && !c_ok) |=> trap_valid && trap_tin == (($past(ls_write)) ? 8'h03 : 8'h02))
    else $error("denied data access without trap");
  if_trap_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ24
    if_valid && !c_ok |=> trap_valid && trap_tin == 8'h04) else $error("denied fetch without trap");
  gw_trap_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ23
    core_greg_write && !program_status_word[8] && !(if_valid && !c_ok) && !(ls_valid && !d_ok) |=> trap_tin == 8'h07)
    else $error("global write trap missing");
  trap_state_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ25
    core_trap_take |=> program_status_word[6:0] == 7'h00 && program_status_word[13:12] == 2'h0) else $error("trap state wrong");
  cd_off_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
    core_call && program_status_word[6:0] == 7'h7f |=> !(trap_valid && trap_class == 3'h3)) else $error("counting not disabled");
  cd_trace_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
    core_call && program_status_word[7] && program_status_word[6:0] == 7'h7e |=> trap_valid) else $error("trace call not trapped");
  call_cde_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
    core_call && !core_trap_take && !core_intr_take |=> program_status_word[7]) else $error("call did not set enable");
  sp_load_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
    core_intr_take && !program_status_word[9] |=> sp_load_isb && sp_value == $past(isb)) else $error("stack base not loaded");
  sfr_priv_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
    sfr_ok |-> $past(program_status_word[11:10]) == 2'h2) else $error("non supervisor reached core registers");
  int_user0_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
    $past(program_status_word[11:10]) == 2'h0 |-> !int_toggle_ok) else $error("user0 toggled interrupts");
endmodule : mpu_top

// ### mpu_core_model.sv
// model of the core side: load/store unit, fetch unit and event pulses
`timescale 1ns/1ps
module mpu_core_model (
  // clock
  input wire logic ref_clk,
  // load/store and fetch requests
  output logic ls_valid,
  output logic ls_write,
  output logic [31:0] ls_addr,
  output logic if_valid,
  output logic [31:0] if_pc,
  // events: call, interrupt, trap, global write, int enable, int disable, register access
  output logic [6:0] ev
);
  // ==========================================================
  // idle address lines carry the inverse of the last value, so stale data never looks valid
  initial begin
    ls_valid = 1'b0;
    ls_write = 1'b0;
    ls_addr = 32'h0;
    if_valid = 1'b0;
    if_pc = 32'h0;
    ev = 7'h0;
  end

  // one data access, held for exactly one sampling edge
  task automatic access(input logic w, input logic [31:0] a);
    @(posedge ref_clk);
    ls_valid <= 1'b1;
    ls_write <= w;
    ls_addr <= a;
    @(posedge ref_clk);
    ls_valid <= 1'b0;
    ls_write <= ~w;
    ls_addr <= ~a;
    #1;
  endtask : access

  // one fetch of a new pc
  task automatic fetch(input logic [31:0] pc);
    @(posedge ref_clk);
    if_valid <= 1'b1;
    if_pc <= pc;
    @(posedge ref_clk);
    if_valid <= 1'b0;
    if_pc <= ~pc;
    #1;
  endtask : fetch

  // one-cycle event pulse
  task automatic pulse(input int k);
    @(posedge ref_clk);
    ev[k] <= 1'b1;
    @(posedge ref_clk);
    ev[k] <= 1'b0;
    #1;
  endtask : pulse
endmodule : mpu_core_model

// ### mpu_top_tb.sv
// self-checking testbench for the memory protection unit
`timescale 1ns/1ps
`include "mpu_defs.svh"
module mpu_top_tb;
  import mpu_pkg::*;
  // ==========================================================
  // signals
  logic ref_clk, rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ls_addr, if_pc, sp_value, rd;
  logic [3:0] s_axi_wstrb, wr_strb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ls_valid, ls_write, if_valid, ls_permit, if_permit, dbg_data, dbg_code, trap_valid;
  logic [2:0] trap_class;
  logic [7:0] trap_tin;
  logic sp_load_isb, int_toggle_ok, sfr_ok, greg_write_ok;
  logic [6:0] ev;
  logic core_call, core_intr_take, core_trap_take, core_greg_write;
  logic core_int_enable_req, core_int_disable_req, core_sfr_access;
  int n_fail, checks_done, cyc;
  assign {core_sfr_access, core_int_disable_req, core_int_enable_req, core_greg_write} = ev[6:3];
  assign {core_trap_take, core_intr_take, core_call} = ev[2:0];

  mpu_top #(.NSETS(4), .ENTRIES(4)) uut (.*);
  mpu_core_model core (.*);

  // ==========================================================
  // clock, reset and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    // address, data and strobe lines stay unknown until the first request; valids low
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    wr_strb = 4'hf;
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask : check

  // ==========================================================
  // axi4-lite master: valids held until each ready, ready held until the response
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= wr_strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // one table entry: bounds words then mode word
  task automatic set_ent(input int s, input int c, input int e, input logic [31:0] lo, up, md);
    logic [11:0] b;
    b = `MPU_OFS_TBL + 12'(s * 256 + c * 128 + e * 16);
    axi_wr(b, lo, rr);
    axi_wr(b + 12'h4, up, rr);
    axi_wr(b + 12'h8, md, rr);
  endtask : set_ent

  // protection fields of the status word
  task automatic set_sw(input logic [1:0] pset, io, input logic st, grw, cde, input logic [6:0] depth);
    axi_wr(`MPU_OFS_PSW, {18'h0, pset, io, st, grw, cde, depth}, rr);
  endtask : set_sw

  // data access, then permit, debug and trap outputs one cycle later
  task automatic ls_chk(input logic w, input logic [31:0] a, input logic p, d, input logic [7:0] tin);
    core.access(w, a);
    check({ls_permit, dbg_data, trap_valid}, {p, d, ~p});
    if (!p) check({trap_class, trap_tin}, {`MPU_TCLS_PROT, tin});
  endtask : ls_chk

  // event pulse, then the answer that belongs to the event and the trap outputs one cycle later
  task automatic ev_chk(input int k, input logic o, input logic [10:0] trap);
    logic so;
    core.pulse(k);
    so = (k == 6) ? sfr_ok : (k == 3) ? greg_write_ok : (k == 4 || k == 5) ? int_toggle_ok : 1'b0;
    check({so, trap_valid, trap_class, trap_tin}, {o, trap != 11'h000, trap});
  endtask : ev_chk

  // ==========================================================
  // scenarios
  initial begin
    @(negedge rst);
    axi_rd(`MPU_OFS_PSW, rd, rr);
    check(rd, `MPU_PSW_RST);
    axi_rd(12'h010, rd, rr);
    check({rr, rd}, {2'b10, 32'h0});
    axi_wr(12'h010, 32'h1, rr);
    check(rr, 2'b10);
    ls_chk(1'b1, 32'h9000, 1'b1, 1'b0, 8'h0);
    // set 0: read-only, read/write, debug-only data ranges; one executable and one debug-only code range
    set_ent(0, 0, 0, 32'h1000, 32'h2000, 32'h40);
    set_ent(0, 0, 1, 32'h3000, 32'h4000, 32'hc0);
    set_ent(0, 0, 2, 32'h5000, 32'h6000, 32'h04);
    set_ent(0, 1, 0, 32'h0100, 32'h0200, 32'h80);
    set_ent(0, 1, 1, 32'h0200, 32'h0300, 32'h10);
    axi_wr(`MPU_OFS_CTRL, 32'h1, rr);
    ls_chk(1'b0, 32'h1000, 1'b1, 1'b0, 8'h0);
    ls_chk(1'b0, 32'h1fff, 1'b1, 1'b0, 8'h0);
    ls_chk(1'b0, 32'h2000, 1'b0, 1'b0, `MPU_TIN_MPR);
    ls_chk(1'b1, 32'h1800, 1'b0, 1'b0, `MPU_TIN_MPW);
    ls_chk(1'b1, 32'h3000, 1'b1, 1'b0, 8'h0);
    ls_chk(1'b0, 32'h5000, 1'b0, 1'b1, `MPU_TIN_MPR);
    ls_chk(1'b0, 32'h5004, 1'b0, 1'b0, `MPU_TIN_MPR);
    core.fetch(32'h0100);
    check({if_permit, trap_valid, dbg_code}, 3'b100);
    core.fetch(32'h0200);
    check({if_permit, trap_valid, dbg_code, trap_class, trap_tin}, {3'b011, `MPU_TCLS_PROT, `MPU_TIN_MPX});
    set_sw(2'b01, 2'b10, 1'b1, 1'b0, 1'b1, 7'h0);
    ls_chk(1'b0, 32'h1000, 1'b0, 1'b0, `MPU_TIN_MPR);
    set_sw(2'b00, 2'b10, 1'b1, 1'b0, 1'b1, 7'h0);
    ls_chk(1'b0, 32'h1000, 1'b1, 1'b0, 8'h0);
    axi_wr(`MPU_OFS_CTRL, 32'h0, rr);
    // privilege levels: int enable 4, int disable 5, register access 6
    set_sw(2'b00, 2'b00, 1'b1, 1'b0, 1'b1, 7'h0);
    ev_chk(5, 1'b0, 11'h0);
    ev_chk(4, 1'b0, 11'h0);
    ev_chk(6, 1'b0, 11'h0);
    set_sw(2'b00, 2'b01, 1'b1, 1'b0, 1'b1, 7'h0);
    ev_chk(5, 1'b1, 11'h0);
    check(32'(int_toggle_ok), 32'h1);
    ev_chk(4, 1'b0, 11'h0);
    ev_chk(6, 1'b0, 11'h0);
    set_sw(2'b00, 2'b10, 1'b1, 1'b0, 1'b1, 7'h0);
    core.pulse(6);
    check(32'(sfr_ok), 32'h1);
    // global register writes
    ev_chk(3, 1'b0, {`MPU_TCLS_PROT, `MPU_TIN_GLOBAL_WRITE_VIOLATION_TRAP});
    set_sw(2'b00, 2'b10, 1'b1, 1'b1, 1'b1, 7'h0);
    core.pulse(3);
    check({greg_write_ok, trap_valid}, 2'b10);
    // stack switch on interrupt
    axi_wr(`MPU_OFS_ISB, 32'h0000_8000, rr);
    set_sw(2'b00, 2'b10, 1'b0, 1'b1, 1'b1, 7'h0);
    core.pulse(1);
    check({sp_load_isb, sp_value}, {1'b1, 32'h0000_8000});
    core.pulse(1);
    check(32'(sp_load_isb), 32'h0);
    // call depth: trace mode, disabled, one-bit counter, enable restored by call
    set_sw(2'b00, 2'b10, 1'b1, 1'b1, 1'b1, 7'h7e);
    ev_chk(0, 1'b0, {`MPU_TCLS_CTX, `MPU_TIN_CDO});
    set_sw(2'b00, 2'b10, 1'b1, 1'b1, 1'b1, 7'h7f);
    ev_chk(0, 1'b0, 11'h0);
    set_sw(2'b00, 2'b10, 1'b1, 1'b1, 1'b1, 7'h7c);
    ev_chk(0, 1'b0, 11'h0);
    axi_rd(`MPU_OFS_PSW, rd, rr);
    check(rd, 32'h0000_0bfd);
    ev_chk(0, 1'b0, {`MPU_TCLS_CTX, `MPU_TIN_CDO});
    set_sw(2'b00, 2'b10, 1'b1, 1'b1, 1'b0, 7'h7e);
    ev_chk(0, 1'b0, 11'h0);
    axi_rd(`MPU_OFS_PSW, rd, rr);
    check(rd, 32'h0000_0bfe);
    // trap entry defaults
    set_sw(2'b11, 2'b00, 1'b0, 1'b0, 1'b0, 7'h55);
    core.pulse(2);
    axi_rd(`MPU_OFS_PSW, rd, rr);
    check(rd, 32'h0000_0b80);
    // byte strobes: only the low byte of the status word may change
    wr_strb = 4'h1;
    set_sw(2'b11, 2'b00, 1'b0, 1'b0, 1'b0, 7'h55);
    wr_strb = 4'hf;
    axi_rd(`MPU_OFS_PSW, rd, rr);
    check(rd, 32'h0000_0b55);
    stop_test;
  end
endmodule : mpu_top_tb
